// ---- verilog/bpg_pkg.sv ----
/*
 * bpg_pkg: register offsets, field widths and reset values of the bus-pin gpio block.
 * assumes a 32-bit avalon-mm slave with byte addressing, one aligned word per register.
 */
package bpg_pkg;
    // ------------------------------------------------------------
    // register map
    // ------------------------------------------------------------
    localparam logic [4:0] BPG_OFS_ADDR_SEL   = 5'h00;
    localparam logic [4:0] BPG_OFS_ADDR_DIR   = 5'h04;
    localparam logic [4:0] BPG_OFS_ADDR_LEVEL = 5'h08;
    localparam logic [4:0] BPG_OFS_HOST_SEL   = 5'h0C;
    localparam logic [4:0] BPG_OFS_HOST_DIR   = 5'h10;
    localparam logic [4:0] BPG_OFS_HOST_LEVEL = 5'h14;
    localparam logic [4:0] BPG_OFS_PORT_MODE  = 5'h18;

    // ------------------------------------------------------------
    // field layout and reset values
    // ------------------------------------------------------------
    localparam int         BPG_ADDR_W      = 16;
    localparam int         BPG_HOST_W      = 6;
    localparam int         BPG_MODE_W      = 2;
    localparam logic [15:0] BPG_ADDR_RST   = 16'h0000;
    localparam logic [5:0]  BPG_HOST_RST   = 6'h00;
    localparam logic [1:0]  BPG_MODE_RST   = 2'h0;
    // lines 15 and 14 exist only in the ball-grid package build
    localparam logic [15:0] BPG_ADDR_MASK_BALL  = 16'hFFFF;
    localparam logic [15:0] BPG_ADDR_MASK_SMALL = 16'h3FFF;

    typedef enum logic [1:0] {
        BPG_MODE_DATA_MEM  = 2'b00,
        BPG_MODE_RSVD      = 2'b01,
        BPG_MODE_HOST_NMUX = 2'b10,
        BPG_MODE_HOST_MUX  = 2'b11
    } bpg_mode_t;
endpackage : bpg_pkg

// ---- verilog/bpg_pin_mux.sv ----
/*
 * bpg_pin_mux: per-line choice between bus function and gpio for a group of pins.
 * assumes the selection, direction and level vectors come from registers.
 */
module bpg_pin_mux #(
    parameter int W = 16
) (
    input  wire logic [W-1:0] allow,
    input  wire logic [W-1:0] gpio_sel,
    input  wire logic [W-1:0] dir,
    input  wire logic [W-1:0] level,
    input  wire logic [W-1:0] bus_out,
    input  wire logic [W-1:0] bus_oe,
    output logic      [W-1:0] pin_out,
    output logic      [W-1:0] pin_oe
);
    logic [W-1:0] own;

    // a line is gpio only when both the mode and its select bit allow it
    assign own     = allow & gpio_sel;
    assign pin_oe  = (own & dir) | (~own & bus_oe);
    assign pin_out = (own & level) | (~own & bus_out);
endmodule : bpg_pin_mux

// ---- verilog/bpg_top.sv ----
/*
 * bpg_top: bus-pin gpio control, registers on avalon-mm and pin muxing.
 * assumes pins are synchronous to clock; the bus functions drive bus_* inputs.
 */
// The Avalon-MM slave port and the register offsets were decided locally.
// Contract
// - address gpio input line reads back the sampled pin level
// - address gpio output line drives the stored level bit
// - address level register is 16 writable bits resetting to zero
// - address lines 15 and 14 exist only in ball-grid build
// - host control lines become gpio only in host port modes 10 or 11
// - host lines use enable, direction and level registers
// - host enable register has six bits, reset zero, upper bits read zero
// - host enable 1 gives gpio, 0 keeps host port control role
// - host direction has six bits, reset zero, 1 output 0 input
// - direction applies only to lines placed in gpio mode; the code also uses it to choose the level readback of every line
// - host level register six bits, reset zero, reads input level; lines with direction 1 read the stored level bit instead
// - address lines may be gpio only in modes 00 or 11
// - address select bit 0 keeps address output, 1 gives gpio
module bpg_top
    import bpg_pkg::*;
#(
    parameter bit BALL_GRID = 1'b1
) (
    input  wire logic        clock,
    input  wire logic        resetn,
    input  wire logic        clk_en,
    input  wire logic [4:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    input  wire logic [3:0]  avs_byteenable,
    output logic      [31:0] avs_readdata,
    output logic             avs_waitrequest,
    input  wire logic [15:0] addr_bus_out,
    input  wire logic [15:0] addr_pin_in,
    output logic      [15:0] addr_pin_out,
    output logic      [15:0] addr_pin_oe,
    input  wire logic [5:0]  host_bus_out,
    input  wire logic [5:0]  host_bus_oe,
    input  wire logic [5:0]  host_pin_in,
    output logic      [5:0]  host_pin_out,
    output logic      [5:0]  host_pin_oe,
    output logic      [1:0]  port_mode
);
    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        logic [15:0] addr_sel;
        logic [15:0] addr_dir;
        logic [15:0] addr_level;
        logic [5:0]  host_sel;
        logic [5:0]  host_dir;
        logic [5:0]  host_level;
        logic [1:0]  mode;
        logic [15:0] addr_samp;
        logic [5:0]  host_samp;
        logic        ack;
        logic [31:0] rdata;
    } bpg_state_t;

    bpg_state_t st_reg;
    bpg_state_t st_next;

    logic [15:0] line_mask;
    logic        addr_allow;
    logic        host_allow;
    logic [15:0] addr_view;
    logic [5:0]  host_view;

    // ------------------------------------------------------------
    // mode decode
    // ------------------------------------------------------------
    assign line_mask  = BALL_GRID ? BPG_ADDR_MASK_BALL : BPG_ADDR_MASK_SMALL;
    assign addr_allow = (st_reg.mode == BPG_MODE_DATA_MEM)
                      || (st_reg.mode == BPG_MODE_HOST_MUX);
    assign host_allow = (st_reg.mode == BPG_MODE_HOST_NMUX)
                      || (st_reg.mode == BPG_MODE_HOST_MUX);

    // input lines report the sampled pin, output lines the stored bit
    assign addr_view = ((st_reg.addr_dir & st_reg.addr_level)
                     | (~st_reg.addr_dir & st_reg.addr_samp)) & line_mask;
    assign host_view = (st_reg.host_dir & st_reg.host_level)
                     | (~st_reg.host_dir & st_reg.host_samp);

    function automatic logic [15:0] merge16(input logic [15:0] old,
                                            input logic [15:0] wd,
                                            input logic [1:0]  be);
        logic [15:0] r;
        r = old;
        if (be[0]) begin
            r[7:0] = wd[7:0];
        end
        if (be[1]) begin
            r[15:8] = wd[15:8];
        end
        return r;
    endfunction : merge16

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        st_next           = st_reg;
        st_next.addr_samp = addr_pin_in;
        st_next.host_samp = host_pin_in;
        st_next.ack       = 1'b0;
        if ((avs_read || avs_write) && !st_reg.ack) begin
            st_next.ack = 1'b1;
        end
        if (avs_write && !st_reg.ack) begin
            case (avs_address)
                BPG_OFS_ADDR_SEL: begin
                    st_next.addr_sel = merge16(st_reg.addr_sel, avs_writedata[15:0],
                                               avs_byteenable[1:0]) & line_mask;
                end
                BPG_OFS_ADDR_DIR: begin
                    st_next.addr_dir = merge16(st_reg.addr_dir, avs_writedata[15:0],
                                               avs_byteenable[1:0]) & line_mask;
                end
                BPG_OFS_ADDR_LEVEL: begin
                    st_next.addr_level = merge16(st_reg.addr_level, avs_writedata[15:0],
                                                 avs_byteenable[1:0]) & line_mask;
                end
                BPG_OFS_HOST_SEL: begin
                    if (avs_byteenable[0]) begin
                        st_next.host_sel = avs_writedata[5:0];
                    end
                end
                BPG_OFS_HOST_DIR: begin
                    if (avs_byteenable[0]) begin
                        st_next.host_dir = avs_writedata[5:0];
                    end
                end
                BPG_OFS_HOST_LEVEL: begin
                    if (avs_byteenable[0]) begin
                        st_next.host_level = avs_writedata[5:0];
                    end
                end
                BPG_OFS_PORT_MODE: begin
                    if (avs_byteenable[0]) begin
                        st_next.mode = avs_writedata[1:0];
                    end
                end
                default: begin
                    st_next.mode = st_reg.mode;
                end
            endcase
        end
        if (avs_read && !st_reg.ack) begin
            case (avs_address)
                BPG_OFS_ADDR_SEL:   st_next.rdata = {16'h0000, st_reg.addr_sel};
                BPG_OFS_ADDR_DIR:   st_next.rdata = {16'h0000, st_reg.addr_dir};
                BPG_OFS_ADDR_LEVEL: st_next.rdata = {16'h0000, addr_view};
                BPG_OFS_HOST_SEL:   st_next.rdata = {26'h0000000, st_reg.host_sel};
                BPG_OFS_HOST_DIR:   st_next.rdata = {26'h0000000, st_reg.host_dir};
                BPG_OFS_HOST_LEVEL: st_next.rdata = {26'h0000000, host_view};
                BPG_OFS_PORT_MODE:  st_next.rdata = {30'h00000000, st_reg.mode};
                default:            st_next.rdata = 32'h00000000;
            endcase
        end
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            st_reg.addr_sel   <= BPG_ADDR_RST;
            st_reg.addr_dir   <= BPG_ADDR_RST;
            st_reg.addr_level <= BPG_ADDR_RST;
            st_reg.host_sel   <= BPG_HOST_RST;
            st_reg.host_dir   <= BPG_HOST_RST;
            st_reg.host_level <= BPG_HOST_RST;
            st_reg.mode       <= BPG_MODE_RST;
            st_reg.addr_samp  <= BPG_ADDR_RST;
            st_reg.host_samp  <= BPG_HOST_RST;
            st_reg.ack        <= 1'b0;
            st_reg.rdata      <= 32'h00000000;
        end else if (clk_en) begin
            st_reg <= st_next;
        end
    end

    // one wait state: the answer lands on the edge after the request is seen
    assign avs_waitrequest = (avs_read || avs_write) && !(st_reg.ack && clk_en);
    assign avs_readdata    = st_reg.rdata;
    assign port_mode       = st_reg.mode;

    // ------------------------------------------------------------
    // pin muxing
    // ------------------------------------------------------------
    // address lines are always driven as outputs in their bus role
    bpg_pin_mux #(.W(16)) u_addr_mux (
        .allow    ({16{addr_allow}} & line_mask),
        .gpio_sel (st_reg.addr_sel),
        .dir      (st_reg.addr_dir),
        .level    (st_reg.addr_level),
        .bus_out  (addr_bus_out),
        .bus_oe   (line_mask),
        .pin_out  (addr_pin_out),
        .pin_oe   (addr_pin_oe)
    );

    bpg_pin_mux #(.W(6)) u_host_mux (
        .allow    ({6{host_allow}}),
        .gpio_sel (st_reg.host_sel),
        .dir      (st_reg.host_dir),
        .level    (st_reg.host_level),
        .bus_out  (host_bus_out),
        .bus_oe   (host_bus_oe),
        .pin_out  (host_pin_out),
        .pin_oe   (host_pin_oe)
    );
endmodule : bpg_top

// ---- dv/bpg_board.sv ----
/* bpg_board: external parts on the repurposed pins.
   assumes the bench sets what those parts drive onto lines the device releases. */
module bpg_board (
    input  wire logic [15:0] addr_pin_out,
    input  wire logic [15:0] addr_pin_oe,
    input  wire logic [15:0] addr_ext,
    input  wire logic [5:0]  host_pin_out,
    input  wire logic [5:0]  host_pin_oe,
    input  wire logic [5:0]  host_ext,
    output logic      [15:0] addr_pin_in,
    output logic      [5:0]  host_pin_in
);
    // a driven line shows the device level, a released one the external part
    assign addr_pin_in = (addr_pin_oe & addr_pin_out) | (~addr_pin_oe & addr_ext);
    assign host_pin_in = (host_pin_oe & host_pin_out) | (~host_pin_oe & host_ext);
endmodule : bpg_board

// ---- dv/bpg_top_sva.sv ----
/* bpg_top_sva: handshake and pin-role checks on the bpg_top ports.
   assumes BALL_GRID=1, so every address line drives in its bus role. */
module bpg_top_sva
    import bpg_pkg::*;
(
    input wire logic        clock,
    input wire logic        resetn,
    input wire logic        clk_en,
    input wire logic [4:0]  avs_address,
    input wire logic        avs_read,
    input wire logic        avs_write,
    input wire logic [31:0] avs_readdata,
    input wire logic        avs_waitrequest,
    input wire logic [15:0] addr_bus_out,
    input wire logic [15:0] addr_pin_out,
    input wire logic [15:0] addr_pin_oe,
    input wire logic [5:0]  host_bus_out,
    input wire logic [5:0]  host_bus_oe,
    input wire logic [5:0]  host_pin_out,
    input wire logic [5:0]  host_pin_oe,
    input wire logic [1:0]  port_mode
);
    default clocking @(posedge clock); endclocking
    default disable iff (!resetn);
    wire req  = avs_read || avs_write;
    wire take = req && avs_waitrequest && clk_en;
    wire mode_wr = take && avs_write && (avs_address == BPG_OFS_PORT_MODE);
    sequence s_take;
        req && avs_waitrequest && clk_en;
    endsequence
    chk_wait_first: assert property ($rose(req) |-> avs_waitrequest)
        else $error("no wait state on new request");
    chk_ack_bound: assert property (s_take ##1 (clk_en && req) |-> !avs_waitrequest)
        else $error("answer later than one cycle");
    chk_ack_single: assert property (req && !avs_waitrequest |=> !req || avs_waitrequest)
        else $error("waitrequest low for more than one cycle");
    chk_rdata_hold: assert property (!(avs_read && take) |=> $stable(avs_readdata))
        else $error("read data changed without a read");
    chk_mode_reset: assert property ($rose(resetn) |-> port_mode == 2'b00)
        else $error("port mode not zero after reset");
    chk_mode_write: assert property ($changed(port_mode) |->
        $past(mode_wr))
        else $error("port mode changed without a write");
    chk_host_bus: assert property (!port_mode[1] |->
        host_pin_out == host_bus_out && host_pin_oe == host_bus_oe)
        else $error("host line left bus role in a non-host mode");
    chk_addr_bus: assert property (port_mode inside {2'b01, 2'b10} |->
        addr_pin_out == addr_bus_out && addr_pin_oe == 16'hFFFF)
        else $error("address line left bus role in a host-only mode");
endmodule : bpg_top_sva

bind bpg_top bpg_top_sva u_sva (.*);

// ---- dv/testbench.sv ----
/* testbench: register and pin-role checks of bpg_top over avalon-mm.
   assumes the board model resolves each line from the drivers' enables. */
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    import bpg_pkg::*;
    logic        clock = 1'b0, resetn = 1'b0, avs_read = 1'b0, avs_write = 1'b0;
    logic        avs_waitrequest, al, hl;
    logic [4:0]  avs_address = 5'h00;
    logic [31:0] avs_writedata = 32'h0, avs_readdata, q;
    logic [15:0] addr_bus_out = 16'h0000, addr_ext = 16'h0000;
    logic [15:0] addr_pin_in, addr_pin_out, addr_pin_oe;
    logic [5:0]  host_bus_out = 6'h00, host_bus_oe = 6'h00, host_ext = 6'h00;
    logic [5:0]  host_pin_in, host_pin_out, host_pin_oe;
    logic [1:0]  port_mode;
    int          err_count = 0, samples_checked = 0, cyc = 0;

    always #12.5 clock = ~clock;

    bpg_top #(.BALL_GRID(1'b1)) dut (.clock(clock), .resetn(resetn), .clk_en(1'b1),
        .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_byteenable(4'hF), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .addr_bus_out(addr_bus_out),
        .addr_pin_in(addr_pin_in), .addr_pin_out(addr_pin_out), .addr_pin_oe(addr_pin_oe),
        .host_bus_out(host_bus_out), .host_bus_oe(host_bus_oe), .host_pin_in(host_pin_in),
        .host_pin_out(host_pin_out), .host_pin_oe(host_pin_oe), .port_mode(port_mode));
    bpg_board board (.addr_pin_out(addr_pin_out), .addr_pin_oe(addr_pin_oe), .addr_ext(addr_ext),
        .host_pin_out(host_pin_out), .host_pin_oe(host_pin_oe), .host_ext(host_ext),
        .addr_pin_in(addr_pin_in), .host_pin_in(host_pin_in));

    task automatic finish_test();
        $display("checks %0d mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : finish_test

    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        samples_checked++;
        if (g !== e) begin
            err_count++;
            $display("mismatch %s expected %h seen %h", n, e, g);
        end
    endtask : chk

    // called right after a rising edge; request held until the edge that sees
    // waitrequest low, read data taken at that same edge, then released
    task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
        avs_address   <= a;
        avs_writedata <= d;
        avs_write     <= w;
        avs_read      <= !w;
        do @(posedge clock); while (avs_waitrequest !== 1'b0);
        q = avs_readdata;
        avs_read  <= 1'b0;
        avs_write <= 1'b0;
        // one idle edge so the next call never re-raises a strobe in this step
        @(posedge clock);
    endtask : bus

    task automatic rd(input logic [4:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        chk($sformatf("reg %h", a), e, q);
    endtask : rd

    task automatic pins(input logic [15:0] ao, ad, input logic [5:0] ho, hd);
        chk("addr_pin_oe", 32'(ao), 32'(addr_pin_oe));
        chk("addr_pin_out", 32'(ad), 32'(addr_pin_out & addr_pin_oe));
        chk("host_pin_oe", 32'(ho), 32'(host_pin_oe));
        chk("host_pin_out", 32'(hd), 32'(host_pin_out & host_pin_oe));
    endtask : pins

    // ------------------------------------------------------------
    // hang guard
    // ------------------------------------------------------------
    always @(posedge clock) begin
        cyc++;
        if (cyc > 2000) begin
            err_count++;
            finish_test();
        end
    end

    initial begin
        repeat (4) @(posedge clock);
        resetn <= 1'b1;
        @(posedge clock);
        for (int i = 0; i < 8; i++) rd(5'(i * 4), 32'h0);
        bus(1'b1, BPG_OFS_HOST_SEL, 32'hFFFFFFFF);
        rd(BPG_OFS_HOST_SEL, 32'h0000003F);
        bus(1'b1, 5'h1C, 32'hFFFFFFFF);
        rd(5'h1C, 32'h0);
        addr_bus_out <= 16'h1234;
        addr_ext     <= 16'h3C00;
        host_bus_out <= 6'h15;
        host_bus_oe  <= 6'h3F;
        host_ext     <= 6'h10;
        bus(1'b1, BPG_OFS_ADDR_SEL, 32'h0000FFF0);
        bus(1'b1, BPG_OFS_ADDR_DIR, 32'h0000FFFF);
        bus(1'b1, BPG_OFS_ADDR_LEVEL, 32'h0000A5C3);
        pins(16'hFFFF, 16'hA5C4, 6'h3F, 6'h15);
        bus(1'b1, BPG_OFS_ADDR_DIR, 32'h000000FF);
        pins(16'h00FF, 16'h00C4, 6'h3F, 6'h15);
        rd(BPG_OFS_ADDR_LEVEL, 32'h00003CC3);
        bus(1'b1, BPG_OFS_HOST_SEL, 32'h0000001F);
        bus(1'b1, BPG_OFS_HOST_DIR, 32'h0000002F);
        bus(1'b1, BPG_OFS_HOST_LEVEL, 32'h0000002A);
        for (int m = 0; m < 4; m++) begin
            bus(1'b1, BPG_OFS_PORT_MODE, 32'(m));
            al = (m == 0 || m == 3);
            hl = (m >= 2);
            pins(al ? 16'h00FF : 16'hFFFF, al ? 16'h00C4 : 16'h1234,
                 hl ? 6'h2F : 6'h3F, hl ? 6'h0A : 6'h15);
            chk("port_mode", 32'(m), 32'(port_mode));
        end
        rd(BPG_OFS_HOST_LEVEL, 32'h0000003A);
        finish_test();
    end
endmodule : testbench
